// ===== rtl/sac_pkg.sv
// Constants, field layout and state types of the converter control block
package sac_pkg;
  // Timing, from the system clock rate
  localparam int CLK_MHZ       = 125;
  localparam int T_CONV_NS     = 1300;
  localparam int T_ACQ_NS      = 240;
  localparam int ACQ_CYCLES    = (T_ACQ_NS * CLK_MHZ + 999) / 1000;      // Least time, rounded up
  localparam int BIT_CYCLES    = ((T_CONV_NS * CLK_MHZ) / 1000) / 12;    // Per-bit share, rounded down
  localparam int SETTLE_CYCLES = 8;                                      // Lets a late write land first
  localparam int CNT_W         = 8;

  // Word sizes
  localparam int RES_BITS   = 12;
  localparam int TRAIL_BITS = 4;
  localparam int CFG_BITS   = 6;
  localparam int BYTE_BITS  = 8;
  localparam int TX_BITS    = RES_BITS + TRAIL_BITS;

  // Field positions of conversion_config_word
  localparam int CFG_SINGLE = 5;   // Input-type select
  localparam int CFG_SWAP   = 4;   // Polarity swap
  localparam int CFG_PAIR_H = 3;   // pair_select_high
  localparam int CFG_PAIR_L = 2;   // pair_select_low
  localparam int CFG_RANGE  = 1;   // range_select, 1 is unipolar
  localparam int CFG_LOWPWR = 0;   // low_power_select
  localparam logic [CFG_BITS-1:0] CFG_RESET = 6'h00;

  // Positions in the synchronised pin vector
  localparam int PIN_SDA  = 0;
  localparam int PIN_SCL  = 1;
  localparam int PIN_COMP = 2;
  localparam int PIN_N    = 3;

  // Bus address of the slave, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h08;

  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_ADDR_ACK, L_RD, L_RD_ACK, L_WR, L_WR_ACK
  } sac_link_state_t;

  typedef enum logic [2:0] {
    S_IDLE, S_SETTLE, S_SAMPLE, S_BITS, S_LATCH
  } sac_conv_state_t;
endpackage : sac_pkg

// ===== rtl/sac_conv_ctrl.sv
// Conversion control behind a two-wire slave port, with config FIFO
//
// Function
// - A conversion starts only on STOP after a successful addressing.
// - Addressing during a conversion gets NACK; afterwards ACK again.
// - Reads return the latest result: 12 bits, then four zeros.
// - Output bits change on SCL falling edge; master samples on rising.
// - After a read, repeated START may write config; STOP starts converting.
// - A write loads a 6-bit configuration word for later conversions.
// - Config bits captured on rising edges, input-type first, low-power sixth.
// - SAR resolves twelve bits MSB first from comparator against DAC trial.
// - Finished approximation word is copied into output holding latches.
// - Differential: pair selects pick 0/1..6/7; swap makes odd positive.
// - Single-ended: positive channel is {pair high, pair low, swap}; negative common.
// - Range select picks unipolar or bipolar; low-power select enables sleep.
// - Bipolar results are two's complement, unipolar straight binary.
// - After each conversion enter sleep if low-power set, else nap.
// - Two trailing bits of the written byte are ignored.
`timescale 1ns/10ps

module sac_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("sac_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [IW-1:0]    wrIdx_reg;
  logic [IW-1:0]    rdIdx_reg;
  logic [CW-1:0]    count_reg;
  logic             doPush;
  logic             doPop;

  // Handshakes from the fill count
  assign inReady  = (count_reg != CW'(DEPTH));
  assign outValid = (count_reg != '0);
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;
  assign outData  = mem_reg[rdIdx_reg];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem_reg[wrIdx_reg] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrIdx_reg <= '0;
      rdIdx_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrIdx_reg <= (wrIdx_reg == IW'(DEPTH - 1)) ? '0 : wrIdx_reg + IW'(1);
      end
      if (doPop) begin
        rdIdx_reg <= (rdIdx_reg == IW'(DEPTH - 1)) ? '0 : rdIdx_reg + IW'(1);
      end
      count_reg <= count_reg + CW'(doPush) - CW'(doPop);
    end
  end
endmodule : sac_fifo

module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = DEV_ADDR_DEFAULT,
  parameter int         FIFO_DEPTH = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                scl,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  input  wire logic                compHigh,
  output logic      [RES_BITS-1:0] dacTrial,
  output logic      [2:0]          muxPosSel,
  output logic      [2:0]          muxNegSel,
  output logic                     muxNegCommon,
  output logic                     bipolarMode,
  output logic                     sampleHold,
  output logic                     convBusy,
  output logic                     sleepMode,
  output logic                     napMode
);
  generate
    if (ACQ_CYCLES >= (1 << CNT_W) || BIT_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W)) begin : g_bad_time
      $error("sac_conv_ctrl timing counts do not fit the counter");
    end
  endgenerate

  // ---------------- Link domain (scl) ----------------
  sac_link_state_t     lstate_reg;
  logic [3:0]          bitCnt_reg;
  logic [TX_BITS-1:0]  txShift_reg;
  logic [BYTE_BITS-1:0] rxShift_reg;
  logic [CFG_BITS-1:0] cfgWord_reg;
  logic                sdaOe_reg;
  logic                sdaRise_reg;
  logic                byteIdx_reg;
  logic                rdMode_reg;
  logic                cfgTog_reg;
  logic                ackTog_reg;
  logic [1:0]          linkRst_reg;
  logic [1:0]          busyLink_reg;
  logic [1:0]          roomLink_reg;
  logic                linkRst;
  logic                startHere;
  logic                addrHit;
  logic                addrOk;
  logic [TX_BITS-1:0]  txLoad;

  // ---------------- System domain ----------------
  sac_conv_state_t     sstate_reg;
  logic [CNT_W-1:0]    waitCnt_reg;
  logic [3:0]          bitIdx_reg;
  logic [RES_BITS-1:0] approx_reg;
  logic [RES_BITS-1:0] approx_next;
  logic [RES_BITS-1:0] hold_reg;
  logic [CFG_BITS-1:0] cfg_reg;
  logic [CFG_BITS-1:0] cfgNow;
  logic [PIN_N-1:0]    pinS1_reg;
  logic [PIN_N-1:0]    pinS2_reg;
  logic [PIN_N-1:0]    pinS3_reg;
  logic [PIN_N-1:0]    pinFilt_reg;
  logic                sdaPrev_reg;
  logic [2:0]          cfgTogS_reg;
  logic [2:0]          ackTogS_reg;
  logic                armed_reg;
  logic                busFree_reg;
  logic                busy_reg;
  logic                room_reg;
  logic                sleep_reg;
  logic                nap_reg;
  logic                sample_reg;
  logic                bipolar_reg;
  logic [2:0]          muxPos_reg;
  logic [2:0]          muxNeg_reg;
  logic                muxCom_reg;
  logic                stopSeen;
  logic                cfgEvent;
  logic                ackEvent;
  logic                convStart;
  logic                cfgPop;
  logic                bitDone;
  logic                fifoInReady;
  logic                fifoOutValid;
  logic [CFG_BITS-1:0] fifoOutData;

  // Sys-domain status into the link clock, two flops each
  always_ff @(posedge scl) begin
    linkRst_reg  <= {linkRst_reg[0], rst};
    busyLink_reg <= {busyLink_reg[0], busy_reg};
    roomLink_reg <= {roomLink_reg[0], room_reg};
  end
  assign linkRst = linkRst_reg[1];

  // Rising-edge capture of the data line
  always_ff @(posedge scl) begin
    sdaRise_reg <= sdaIn;
    rxShift_reg <= {rxShift_reg[BYTE_BITS-2:0], sdaIn};
  end

  // START shows at the next falling edge: line high at the last rise, or bus freed by a STOP
  assign startHere = ~sdaIn & (sdaRise_reg | busFree_reg);
  assign addrHit   = (rxShift_reg[BYTE_BITS-1:1] == DEV_ADDR);
  assign addrOk    = addrHit & ~busyLink_reg[1] & (rxShift_reg[0] | roomLink_reg[1]);
  // Holding latches are stable whenever the synchronised busy flag is low
  assign txLoad    = {hold_reg, {TRAIL_BITS{1'b0}}};

  // Serial protocol engine, all driving on falling edges
  always_ff @(negedge scl) begin
    if (linkRst) begin
      lstate_reg  <= L_IDLE;
      bitCnt_reg  <= '0;
      sdaOe_reg   <= 1'b0;
      txShift_reg <= '0;
      byteIdx_reg <= 1'b0;
      rdMode_reg  <= 1'b0;
      cfgTog_reg  <= 1'b0;
      ackTog_reg  <= 1'b0;
      cfgWord_reg <= CFG_RESET;
    end else if (startHere) begin
      lstate_reg  <= L_ADDR;
      bitCnt_reg  <= '0;
      sdaOe_reg   <= 1'b0;
      byteIdx_reg <= 1'b0;
    end else begin
      case (lstate_reg)
        L_ADDR: begin
          if (bitCnt_reg == 4'(BYTE_BITS - 1)) begin
            bitCnt_reg <= '0;
            if (addrOk) begin
              sdaOe_reg  <= 1'b1;
              rdMode_reg <= rxShift_reg[0];
              ackTog_reg <= ~ackTog_reg;
              lstate_reg <= L_ADDR_ACK;
            end else begin
              lstate_reg <= L_IDLE;
            end
          end else begin
            bitCnt_reg <= bitCnt_reg + 4'(1);
          end
        end
        L_ADDR_ACK: begin
          if (rdMode_reg) begin
            sdaOe_reg   <= ~txLoad[TX_BITS-1];
            txShift_reg <= {txLoad[TX_BITS-2:0], 1'b0};
            lstate_reg  <= L_RD;
          end else begin
            sdaOe_reg   <= 1'b0;
            lstate_reg  <= L_WR;
          end
        end
        L_RD: begin
          if (bitCnt_reg == 4'(BYTE_BITS - 1)) begin
            bitCnt_reg <= '0;
            sdaOe_reg  <= 1'b0;
            lstate_reg <= L_RD_ACK;
          end else begin
            bitCnt_reg  <= bitCnt_reg + 4'(1);
            sdaOe_reg   <= ~txShift_reg[TX_BITS-1];
            txShift_reg <= {txShift_reg[TX_BITS-2:0], 1'b0};
          end
        end
        L_RD_ACK: begin
          if (!sdaRise_reg && !byteIdx_reg) begin
            byteIdx_reg <= 1'b1;
            sdaOe_reg   <= ~txShift_reg[TX_BITS-1];
            txShift_reg <= {txShift_reg[TX_BITS-2:0], 1'b0};
            lstate_reg  <= L_RD;
          end else begin
            sdaOe_reg  <= 1'b0;
            lstate_reg <= L_IDLE;
          end
        end
        L_WR: begin
          if (bitCnt_reg == 4'(BYTE_BITS - 1)) begin
            bitCnt_reg  <= '0;
            cfgWord_reg <= rxShift_reg[BYTE_BITS-1 -: CFG_BITS];
            cfgTog_reg  <= ~cfgTog_reg;
            sdaOe_reg   <= 1'b1;
            lstate_reg  <= L_WR_ACK;
          end else begin
            bitCnt_reg <= bitCnt_reg + 4'(1);
          end
        end
        L_WR_ACK: begin
          sdaOe_reg  <= 1'b0;
          lstate_reg <= L_IDLE;
        end
        default: begin
          sdaOe_reg  <= 1'b0;
          lstate_reg <= L_IDLE;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_reg;

  // Pin inputs: three flops, a change counts once the second and third agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinS1_reg   <= '0;
      pinS2_reg   <= '0;
      pinS3_reg   <= '0;
      pinFilt_reg <= {1'b0, 1'b1, 1'b1};
      sdaPrev_reg <= 1'b1;
    end else begin
      pinS1_reg   <= {compHigh, scl, sdaIn};
      pinS2_reg   <= pinS1_reg;
      pinS3_reg   <= pinS2_reg;
      pinFilt_reg <= (~(pinS2_reg ^ pinS3_reg) & pinS3_reg) | ((pinS2_reg ^ pinS3_reg) & pinFilt_reg);
      sdaPrev_reg <= pinFilt_reg[PIN_SDA];
    end
  end
  assign stopSeen = pinFilt_reg[PIN_SCL] & pinFilt_reg[PIN_SDA] & ~sdaPrev_reg;

  // Bus free after a STOP until the clock is seen low; the link reads it as a level,
  // set well before a START lowers the clock and cleared about five cycles after that fall,
  // so the time from that fall to the link's next falling edge must outlast that delay
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busFree_reg <= 1'b0;
    end else if (stopSeen) begin
      busFree_reg <= 1'b1;
    end else if (!pinFilt_reg[PIN_SCL]) begin
      busFree_reg <= 1'b0;
    end
  end

  // Toggle crossings from the link, and status registered for the link
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfgTogS_reg <= '0;
      ackTogS_reg <= '0;
      room_reg    <= 1'b0;
    end else begin
      cfgTogS_reg <= {cfgTogS_reg[1:0], cfgTog_reg};
      ackTogS_reg <= {ackTogS_reg[1:0], ackTog_reg};
      room_reg    <= fifoInReady;
    end
  end
  assign cfgEvent = cfgTogS_reg[1] ^ cfgTogS_reg[2];
  assign ackEvent = ackTogS_reg[1] ^ ackTogS_reg[2];

  // Armed by an accepted address; a new address wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= ackEvent | (armed_reg & ~convStart);
    end
  end

  sac_fifo #(
    .WIDTH (CFG_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_cfg_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (cfgEvent),
    .inReady  (fifoInReady),
    .inData   (cfgWord_reg),
    .outValid (fifoOutValid),
    .outReady (cfgPop),
    .outData  (fifoOutData)
  );

  assign convStart = (sstate_reg == S_IDLE) & stopSeen & armed_reg;
  assign cfgPop    = (sstate_reg == S_SETTLE) & (waitCnt_reg == CNT_W'(SETTLE_CYCLES - 1));
  assign cfgNow    = fifoOutValid ? fifoOutData : cfg_reg;
  assign bitDone   = (waitCnt_reg == CNT_W'(BIT_CYCLES - 1));

  // Stored configuration word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (cfgPop && fifoOutValid) begin
      cfg_reg <= fifoOutData;
    end
  end

  // Trial update: keep or drop the current bit, raise the next one
  always_comb begin
    approx_next = approx_reg;
    approx_next[bitIdx_reg] = pinFilt_reg[PIN_COMP];
    if (bitIdx_reg != 4'(0)) begin
      approx_next[bitIdx_reg - 4'(1)] = 1'b1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sstate_reg  <= S_IDLE;
      waitCnt_reg <= '0;
      bitIdx_reg  <= '0;
      approx_reg  <= '0;
      busy_reg    <= 1'b0;
      sample_reg  <= 1'b0;
    end else begin
      case (sstate_reg)
        S_IDLE: begin
          if (convStart) begin
            sstate_reg  <= S_SETTLE;
            waitCnt_reg <= '0;
            busy_reg    <= 1'b1;
          end
        end
        S_SETTLE: begin
          waitCnt_reg <= cfgPop ? '0 : waitCnt_reg + CNT_W'(1);
          if (cfgPop) begin
            sstate_reg <= S_SAMPLE;
            sample_reg <= 1'b1;
          end
        end
        S_SAMPLE: begin
          if (waitCnt_reg == CNT_W'(ACQ_CYCLES - 1)) begin
            sstate_reg  <= S_BITS;
            sample_reg  <= 1'b0;
            waitCnt_reg <= '0;
            bitIdx_reg  <= 4'(RES_BITS - 1);
            approx_reg  <= 12'h800;
          end else begin
            waitCnt_reg <= waitCnt_reg + CNT_W'(1);
          end
        end
        S_BITS: begin
          waitCnt_reg <= bitDone ? '0 : waitCnt_reg + CNT_W'(1);
          if (bitDone) begin
            approx_reg <= approx_next;
            bitIdx_reg <= bitIdx_reg - 4'(1);
            if (bitIdx_reg == 4'(0)) begin
              sstate_reg <= S_LATCH;
            end
          end
        end
        S_LATCH: begin
          sstate_reg <= S_IDLE;
          busy_reg   <= 1'b0;
        end
        default: begin
          sstate_reg <= S_IDLE;
          busy_reg   <= 1'b0;
        end
      endcase
    end
  end

  // Output holding latches and power mode after each conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_reg  <= '0;
      sleep_reg <= 1'b0;
      nap_reg   <= 1'b0;
    end else if (sstate_reg == S_LATCH) begin
      hold_reg  <= {approx_reg[RES_BITS-1] ^ bipolar_reg, approx_reg[RES_BITS-2:0]};
      sleep_reg <= cfg_reg[CFG_LOWPWR];
      nap_reg   <= ~cfg_reg[CFG_LOWPWR];
    end else if (convStart) begin
      sleep_reg <= 1'b0;
      nap_reg   <= 1'b0;
    end
  end

  // Multiplexer and range set up as the configuration is taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      muxPos_reg  <= '0;
      muxNeg_reg  <= '0;
      muxCom_reg  <= 1'b0;
      bipolar_reg <= 1'b0;
    end else if (cfgPop) begin
      muxPos_reg  <= {cfgNow[CFG_PAIR_H], cfgNow[CFG_PAIR_L], cfgNow[CFG_SWAP]};
      muxNeg_reg  <= {cfgNow[CFG_PAIR_H], cfgNow[CFG_PAIR_L], ~cfgNow[CFG_SWAP]};
      muxCom_reg  <= cfgNow[CFG_SINGLE];
      bipolar_reg <= ~cfgNow[CFG_RANGE];
    end
  end

  assign dacTrial     = approx_reg;
  assign muxPosSel    = muxPos_reg;
  assign muxNegSel    = muxNeg_reg;
  assign muxNegCommon = muxCom_reg;
  assign bipolarMode  = bipolar_reg;
  assign sampleHold   = sample_reg;
  assign convBusy     = busy_reg;
  assign sleepMode    = sleep_reg;
  assign napMode      = nap_reg;

  // ---------------- Checks ----------------
  sequence s_latch_step;
    sstate_reg == S_LATCH;
  endsequence

  a_busy_nack: assert property (@(negedge scl) disable iff (linkRst)
    (lstate_reg == L_ADDR && bitCnt_reg == 4'(BYTE_BITS - 1) && busyLink_reg[1] && !startHere)
    |=> !sdaOe_reg && lstate_reg == L_IDLE) else $error("addressed while busy but not NACKed");

  a_write_ack: assert property (@(negedge scl) disable iff (linkRst)
    (lstate_reg == L_WR && bitCnt_reg == 4'(BYTE_BITS - 1) && !startHere)
    |=> sdaOe_reg && cfgTog_reg != $past(cfgTog_reg)) else $error("write byte not acked or not passed on");

  a_stop_starts: assert property (@(posedge clk_sys) disable iff (rst)
    (sstate_reg == S_IDLE && stopSeen && armed_reg) |=> sstate_reg == S_SETTLE && convBusy)
    else $error("armed STOP did not start a conversion");

  a_no_start: assert property (@(posedge clk_sys) disable iff (rst)
    (sstate_reg == S_IDLE && !armed_reg) |=> sstate_reg == S_IDLE) else $error("conversion without addressing");

  a_sar_order: assert property (@(posedge clk_sys) disable iff (rst)
    (sstate_reg == S_BITS && bitDone && bitIdx_reg != 4'(0))
    |=> bitIdx_reg == $past(bitIdx_reg) - 4'(1) && approx_reg[bitIdx_reg] == 1'b1)
    else $error("successive approximation out of order");

  a_hold_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_latch_step |=> hold_reg == {$past(approx_reg[RES_BITS-1]) ^ bipolar_reg, $past(approx_reg[RES_BITS-2:0])}
    ##1 !convBusy) else $error("result latch or coding wrong");

  a_power_after: assert property (@(posedge clk_sys) disable iff (rst)
    s_latch_step |=> sleepMode == cfg_reg[CFG_LOWPWR] && napMode == !cfg_reg[CFG_LOWPWR])
    else $error("wrong power mode after conversion");

  a_cfg_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !(cfgPop && fifoOutValid) |=> $stable(cfg_reg)) else $error("configuration changed without a write");

  a_mux_map: assert property (@(posedge clk_sys) disable iff (rst)
    (sstate_reg == S_SAMPLE) |-> muxPosSel[0] == cfg_reg[CFG_SWAP] && muxNegSel[0] == !cfg_reg[CFG_SWAP]
    && muxNegCommon == cfg_reg[CFG_SINGLE]) else $error("multiplexer selection does not follow config");
endmodule : sac_conv_ctrl

// ===== dv/sac_i2c_master.sv
// Two-wire bus master model that drives the link from the far side
`timescale 1ns/10ps
module sac_i2c_master #(
  parameter int HALF = 24
) (
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sdaLine
);
  // Clock idles high and the data line is released between frames
  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  // One bit: drive in the low phase, sample on the rise
  task automatic bit_xfer(input logic b, output logic q);
    #6 sdaDrv = b;
    #(HALF - 6) scl = 1'b1;
    q = sdaLine;
    #HALF scl = 1'b0;
  endtask : bit_xfer

  // Also serves as the repeated start between transfers
  task automatic start_cond();
    #6 sdaDrv = 1'b1;
    #(HALF - 6) scl = 1'b1;
    #HALF sdaDrv = 1'b0;
    #HALF scl = 1'b0;
  endtask : start_cond

  // Ends a frame; after a successful addressing it starts a conversion
  task automatic stop_cond();
    #6 sdaDrv = 1'b0;
    #(HALF - 6) scl = 1'b1;
    #HALF sdaDrv = 1'b1;
    #HALF;
  endtask : stop_cond

  // Eight data bits MSB first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] d, input logic mAck, output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], b);
      q[i] = b;
    end
    bit_xfer(mAck, b);
    ack = ~b;
  endtask : byte_xfer

  // Clock pulses with the data line high, used while reset settles
  task automatic idle_clocks(input int n);
    logic b;
    repeat (n) bit_xfer(1'b1, b);
  endtask : idle_clocks
endmodule : sac_i2c_master

// ===== dv/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_top;
  import sac_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] vin     = 12'h000;
  logic        scl, sdaDrv, sdaOut, sdaOe, compHigh, sampleHold, convBusy;
  logic        sleepMode, napMode, muxNegCommon, bipolarMode, a1;
  logic [11:0] dacTrial;
  logic [2:0]  muxPosSel, muxNegSel;
  logic [15:0] rd;
  wire         sdaLine;
  int          err_count = 0;
  int          cmp_count = 0;
  // Nibbles: mux code, positive channel, negative channel, common flag
  logic [15:0] rows [16] = '{16'h0010, 16'h1230, 16'h2450, 16'h3670, 16'h4100, 16'h5320, 16'h6540, 16'h7760,
                             16'h8001, 16'h9201, 16'hA401, 16'hB601, 16'hC101, 16'hD301, 16'hE501, 16'hF701};

  always #4 clk_sys = ~clk_sys;
  // Open-drain wire with pull-up; comparator of an ideal input
  assign sdaLine  = sdaDrv & ~(sdaOe & ~sdaOut);
  assign compHigh = (dacTrial <= vin) === 1'b1;

  sac_conv_ctrl #(.DEV_ADDR(DEV_ADDR_DEFAULT), .FIFO_DEPTH(8)) sac_conv_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .compHigh(compHigh), .dacTrial(dacTrial), .muxPosSel(muxPosSel), .muxNegSel(muxNegSel),
    .muxNegCommon(muxNegCommon), .bipolarMode(bipolarMode), .sampleHold(sampleHold),
    .convBusy(convBusy), .sleepMode(sleepMode), .napMode(napMode));
  sac_i2c_master sac_i2c_master_i (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Address byte, then one written byte or two read bytes
  task automatic frame(input logic rw, input logic [7:0] wb, output logic ackA, output logic [15:0] r);
    logic [7:0] q;
    logic       a;
    r = 16'h0000;
    sac_i2c_master_i.byte_xfer({DEV_ADDR_DEFAULT, rw}, 1'b1, q, ackA);
    if (ackA && rw) begin
      sac_i2c_master_i.byte_xfer(8'hFF, 1'b0, r[15:8], a);
      sac_i2c_master_i.byte_xfer(8'hFF, 1'b1, r[7:0], a);
    end else if (ackA) begin
      sac_i2c_master_i.byte_xfer(wb, 1'b1, q, a);
    end
  endtask : frame

  // Bounded wait for a whole conversion, or for its absence
  task automatic wait_conv(input logic exp);
    int   n;
    logic seen;
    logic smp;
    logic pre;
    n    = 0;
    seen = 1'b0;
    smp  = 1'b0;
    pre  = convBusy;
    while (n < 300 && !(seen && convBusy === 1'b0) && (seen || n < 60)) begin
      @(negedge clk_sys);
      n++;
      if (convBusy === 1'b1) seen = 1'b1;
      if (sampleHold === 1'b1) smp = 1'b1;
    end
    chk(seen && convBusy === 1'b0, exp, "conversion");
    if (pre === 1'b0) chk(smp, exp, "acquisition");
  endtask : wait_conv

  task automatic check_out(input logic [15:0] row, input logic [5:0] cfg);
    chk(muxPosSel, row[10:8], "positive channel");
    chk(muxNegCommon, row[0], "common input");
    if (!row[0]) chk(muxNegSel, row[6:4], "negative channel");
    chk(bipolarMode, !cfg[CFG_RANGE], "range");
    chk({sleepMode, napMode}, {cfg[CFG_LOWPWR], !cfg[CFG_LOWPWR]}, "power mode");
  endtask : check_out

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog against a hang anywhere in the sequence
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [5:0]  cfg;
    logic [11:0] expRes;
    // Reset spans link clock pulses so the link side clears too
    sac_i2c_master_i.idle_clocks(3);
    @(negedge clk_sys) rst = 1'b0;
    sac_i2c_master_i.idle_clocks(3);
    chk({convBusy, sdaOe, sleepMode, napMode}, 4'h0, "after reset");
    sac_i2c_master_i.start_cond();
    frame(1'b1, 8'h00, a1, rd);
    sac_i2c_master_i.stop_cond();
    wait_conv(1'b1);
    check_out(16'h0010, 6'h00);
    $display("test reset done");
    // Every mux code, both ranges and power modes, varied don't-care bits
    for (int i = 0; i < 16; i++) begin
      cfg = {rows[i][15:12], i[0], i[1]};
      vin = 12'(i * 16'h0111);
      sac_i2c_master_i.start_cond();
      frame(1'b0, {cfg, i[1:0]}, a1, rd);
      sac_i2c_master_i.stop_cond();
      wait_conv(1'b1);
      check_out(rows[i], cfg);
      sac_i2c_master_i.start_cond();
      frame(1'b1, 8'h00, a1, rd);
      sac_i2c_master_i.stop_cond();
      expRes = cfg[CFG_RANGE] ? vin : vin ^ 12'h800;
      chk({a1, rd}, {1'b1, expRes, 4'h0}, "read result");
      wait_conv(1'b1);
      check_out(rows[i], cfg);
    end
    $display("test rows done");
    // Addressing while converting is refused; its STOP starts nothing
    sac_i2c_master_i.start_cond();
    frame(1'b1, 8'h00, a1, rd);
    chk(a1, 1'b1, "idle addressing");
    sac_i2c_master_i.stop_cond();
    sac_i2c_master_i.start_cond();
    frame(1'b0, 8'h00, a1, rd);
    chk(a1, 1'b0, "busy addressing");
    sac_i2c_master_i.stop_cond();
    wait_conv(1'b1);
    wait_conv(1'b0);
    $display("test busy done");
    // Read, repeated start, write, then STOP converts with the new word
    sac_i2c_master_i.start_cond();
    frame(1'b1, 8'h00, a1, rd);
    sac_i2c_master_i.start_cond();
    frame(1'b0, 8'hB4, a1, rd);
    sac_i2c_master_i.stop_cond();
    wait_conv(1'b1);
    check_out(16'hB601, 6'h2D);
    $display("test restart done");
    // Queue writes until the buffer refuses, then drain by conversions
    sac_i2c_master_i.start_cond();
    for (int k = 0; k < 9; k++) begin
      frame(1'b0, 8'h04, a1, rd);
      chk(a1, k < 8, "buffer accept");
      sac_i2c_master_i.start_cond();
    end
    sac_i2c_master_i.stop_cond();
    wait_conv(1'b1);
    for (int k = 0; k < 7; k++) begin
      sac_i2c_master_i.start_cond();
      frame(1'b1, 8'h00, a1, rd);
      sac_i2c_master_i.stop_cond();
      wait_conv(1'b1);
    end
    check_out(16'h0010, 6'h01);
    $display("test buffer done");
    report_and_stop();
  end
endmodule : tb_top
